// file: rtl/dac_pkg.sv
// Functional notes
// - The sample word is 12-bit plain unsigned binary, bit 11 the MSB.
// - An all-ones code steers full scale to the primary output.
// - The word is taken at each rising sample clock edge while the two-entry buffer has room, then shown.
// - The block runs at any sample clock rate up to a quarter of the system clock rate, well under the top rate.
// - Any duty cycle is taken if each phase meets the least pulse width.
// - Sleep held high powers down and switches the output current off.
// - Sleep left open reads low, so the block stays converting.
// - Power-down ends within 50 ns; power-up takes about 5 us.
// - Primary is code/4096 of full scale, complementary (4095-code)/4096.
package dac_pkg;
  localparam int unsigned SAMPLE_WIDTH = 12;
  localparam logic [11:0] FULL_CODE = 12'hfff;
  localparam int unsigned MAX_RATE_MSPS = 165;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PWRDN_MAX_NS = 50;
  localparam int unsigned PWRUP_NS = 5000;
  localparam int unsigned PWRDN_CYCLES = PWRDN_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_CYCLES =
    (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_WAKE = 3'b100
  } pwr_state_e;
endpackage : dac_pkg

// file: rtl/sample_stream_if.sv
`timescale 1ns/100ps
interface sample_stream_if #(parameter int unsigned WIDTH = 12);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sample_stream_if

// file: rtl/sample_buffer.sv
`timescale 1ns/100ps
module sample_buffer #(
  parameter int unsigned WIDTH = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Streams
  sample_stream_if.snk fill,
  sample_stream_if.src drain
);
  logic [WIDTH-1:0] mem_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic doWrite;
  logic doRead;

  assign fill.ready = (count_q != 2'h2);
  assign drain.valid = (count_q != 2'h0);
  assign drain.data = mem_q[rdPtr_q];
  assign doWrite = fill.valid && fill.ready;
  assign doRead = drain.valid && drain.ready;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q <= 1'b0;
    end else if (doWrite) begin
      mem_q[wrPtr_q] <= fill.data;
      wrPtr_q <= ~wrPtr_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdPtr_q <= 1'b0;
    end else if (doRead) begin
      rdPtr_q <= ~rdPtr_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= 2'h0;
    end else if (doWrite && !doRead) begin
      count_q <= count_q + 2'h1;
    end else if (doRead && !doWrite) begin
      count_q <= count_q - 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_buffer_full: assert property (count_q == 2'h2 |-> !fill.ready)
    else $error("buffer takes a word while full");
  chk_buffer_hold: assert property (
    drain.valid && !drain.ready |=> drain.valid && $stable(drain.data))
    else $error("stalled word changed or vanished");
endmodule : sample_buffer

// file: rtl/dac_sample_latch_sleep.sv
`timescale 1ns/100ps
module dac_sample_latch_sleep #(
  parameter int unsigned WIDTH = dac_pkg::SAMPLE_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Source pins
  input wire logic sampleClk,
  input wire logic [WIDTH-1:0] sampleWord,
  input wire logic sleepPin,
  // Converter core side
  input wire logic codeAccept,
  output logic [WIDTH-1:0] primaryCode_q,
  output logic [WIDTH-1:0] complementaryCode_q,
  output logic outputEnabled_q,
  output logic powerDown_q,
  output logic sampleDropped_q
);
  if (WIDTH != dac_pkg::SAMPLE_WIDTH) begin : gen_width_check
    $error("only a 12-bit sample word is served");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] clkSync_q;
  logic [2:0] sleepSync_q;
  logic [WIDTH-1:0] dataSync_q [3];
  logic clkLevel_q;
  logic captureEdge;
  logic sleepHigh;
  logic sleepLow;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkSync_q <= 3'h0;
      sleepSync_q <= 3'h0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], sampleClk};
      sleepSync_q <= {sleepSync_q[1:0], sleepPin};
    end
  end

  // Data pipe keeps step with the clock synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        dataSync_q[i] <= '0;
      end
    end else begin
      dataSync_q[0] <= sampleWord;
      dataSync_q[1] <= dataSync_q[0];
      dataSync_q[2] <= dataSync_q[1];
    end
  end

  // Filtered clock level; a change counts once stages agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkLevel_q <= 1'b0;
    end else if (clkSync_q[1] == clkSync_q[2]) begin
      clkLevel_q <= clkSync_q[2];
    end
  end

  assign captureEdge = (clkSync_q[1] == clkSync_q[2]) && clkSync_q[2]
    && !clkLevel_q;
  assign sleepHigh = sleepSync_q[1] && sleepSync_q[2];
  assign sleepLow = !sleepSync_q[1] && !sleepSync_q[2];

  // ------------------------------------------------------------
  // Master stage into the two-entry buffer
  // ------------------------------------------------------------
  sample_stream_if #(.WIDTH(WIDTH)) fillIf ();
  sample_stream_if #(.WIDTH(WIDTH)) drainIf ();

  assign fillIf.valid = captureEdge;
  assign fillIf.data = dataSync_q[2];

  sample_buffer #(.WIDTH(WIDTH)) u_buffer (
    .sys_clk(sys_clk),
    .rst(rst),
    .fill(fillIf),
    .drain(drainIf)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sampleDropped_q <= 1'b0;
    end else begin
      sampleDropped_q <= captureEdge && !fillIf.ready;
    end
  end

  // ------------------------------------------------------------
  // Slave stage
  // ------------------------------------------------------------
  logic [WIDTH-1:0] lastCode_q;

  assign drainIf.ready = codeAccept;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lastCode_q <= '0;
    end else if (drainIf.valid && drainIf.ready) begin
      lastCode_q <= drainIf.data;
    end
  end

  // ------------------------------------------------------------
  // Sleep control
  // ------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(dac_pkg::PWRUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] WAKE_LAST =
    CNT_W'(dac_pkg::PWRUP_CYCLES - 1);

  dac_pkg::pwr_state_e state_q;
  dac_pkg::pwr_state_e state_d;
  logic [CNT_W-1:0] wakeCnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      dac_pkg::PWR_ACTIVE: begin
        if (sleepHigh) begin
          state_d = dac_pkg::PWR_SLEEP;
        end
      end
      dac_pkg::PWR_SLEEP: begin
        if (sleepLow) begin
          state_d = dac_pkg::PWR_WAKE;
        end
      end
      dac_pkg::PWR_WAKE: begin
        if (sleepHigh) begin
          state_d = dac_pkg::PWR_SLEEP;
        end else if (wakeCnt_q == WAKE_LAST) begin
          state_d = dac_pkg::PWR_ACTIVE;
        end
      end
      default: begin
        state_d = dac_pkg::PWR_SLEEP;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= dac_pkg::PWR_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wakeCnt_q <= '0;
    end else if (state_q == dac_pkg::PWR_WAKE) begin
      wakeCnt_q <= wakeCnt_q + CNT_W'(1);
    end else begin
      wakeCnt_q <= '0;
    end
  end

  // ------------------------------------------------------------
  // Output codes
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      primaryCode_q <= '0;
      complementaryCode_q <= '0;
      outputEnabled_q <= 1'b0;
      powerDown_q <= 1'b0;
    end else if (state_d == dac_pkg::PWR_ACTIVE) begin
      primaryCode_q <= lastCode_q;
      complementaryCode_q <= dac_pkg::FULL_CODE - lastCode_q;
      outputEnabled_q <= 1'b1;
      powerDown_q <= 1'b0;
    end else begin
      primaryCode_q <= '0;
      complementaryCode_q <= '0;
      outputEnabled_q <= 1'b0;
      powerDown_q <= (state_d == dac_pkg::PWR_SLEEP);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_sleep_off: assert property (
    sleepHigh |=> !outputEnabled_q && powerDown_q)
    else $error("output still on after sleep seen");
  chk_off_zero: assert property (
    !outputEnabled_q |-> primaryCode_q == '0 && complementaryCode_q == '0)
    else $error("current flows while powered down");
  chk_code_split: assert property (
    outputEnabled_q |-> primaryCode_q + complementaryCode_q
      == dac_pkg::FULL_CODE)
    else $error("outputs do not split full scale");
  chk_wake_dark: assert property (
    state_q == dac_pkg::PWR_WAKE |-> !outputEnabled_q)
    else $error("output valid during power-up");
  chk_wake_done: assert property (
    state_q == dac_pkg::PWR_WAKE && !sleepHigh && wakeCnt_q == WAKE_LAST
      |=> outputEnabled_q && primaryCode_q == $past(lastCode_q))
    else $error("power-up did not end on time");
  chk_latch_update: assert property (
    drainIf.valid && codeAccept |=> lastCode_q == $past(drainIf.data))
    else $error("slave stage missed a word");
  chk_edge_single: assert property (
    captureEdge |=> !captureEdge)
    else $error("one clock edge captured twice");
  chk_drop_flag: assert property (
    captureEdge && !fillIf.ready |=> sampleDropped_q)
    else $error("lost word not flagged");
  chk_wake_start: assert property (
    state_q == dac_pkg::PWR_SLEEP && sleepLow |=> state_q == dac_pkg::PWR_WAKE
      && !powerDown_q && !outputEnabled_q)
    else $error("power-up did not start");
  chk_sleep_stays: assert property (
    powerDown_q && !sleepLow |=> powerDown_q)
    else $error("left sleep while pin still high");
endmodule : dac_sample_latch_sleep

// file: sim/sample_source.sv
`timescale 1ns/100ps
module sample_source (
  // Clock
  input wire logic sys_clk,
  // Source pins
  output logic sampleClk,
  output logic [11:0] sampleWord
);
  initial begin
    sampleClk = 1'b0;
    sampleWord = 12'h000;
  end
  // -------------------------------------
  // One sample, entered at a falling edge
  // -------------------------------------
  task automatic send(input logic [11:0] word, input int hi, input int lo);
    sampleWord = word;
    repeat (lo) @(negedge sys_clk);
    sampleClk = 1'b1;
    repeat (hi) @(negedge sys_clk);
    sampleClk = 1'b0;
  endtask : send
endmodule : sample_source

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk;
  logic rst;
  logic sampleClk;
  logic [11:0] sampleWord;
  logic sleepPin;
  logic codeAccept;
  logic [11:0] primaryCode_q;
  logic [11:0] complementaryCode_q;
  logic outputEnabled_q;
  logic powerDown_q;
  logic sampleDropped_q;
  int err_total;
  int checks;
  int cycles;
  int dropCount;
  localparam logic [11:0] CODES [5] = '{12'h000, 12'hfff, 12'h800,
    12'h001, 12'ha5c};

  sample_source sample_source_i (
    .sys_clk(sys_clk),
    .sampleClk(sampleClk),
    .sampleWord(sampleWord)
  );
  dac_sample_latch_sleep dac_sample_latch_sleep_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .sampleClk(sampleClk),
    .sampleWord(sampleWord),
    .sleepPin(sleepPin),
    .codeAccept(codeAccept),
    .primaryCode_q(primaryCode_q),
    .complementaryCode_q(complementaryCode_q),
    .outputEnabled_q(outputEnabled_q),
    .powerDown_q(powerDown_q),
    .sampleDropped_q(sampleDropped_q)
  );

  // ------------------
  // Clock and watchers
  // ------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (sampleDropped_q === 1'b1) dropCount++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // -------
  // Helpers
  // -------
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic check(input string what, input logic [11:0] seen,
      input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp=%h seen=%h", what, exp, seen);
    end
  endtask : check
  task automatic check_codes(input logic [11:0] w);
    check("primary", primaryCode_q, w);
    check("complementary", complementaryCode_q, dac_pkg::FULL_CODE - w);
  endtask : check_codes
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------
  // Scenarios
  // ---------
  task automatic test_codes();
    foreach (CODES[i]) begin
      sample_source_i.send(CODES[i], 4, 4);
      tick(10);
      check_codes(CODES[i]);
    end
    $display("test codes done");
  endtask : test_codes
  task automatic test_fast_skew();
    sample_source_i.send(12'h5a3, 3, 8);
    sample_source_i.send(12'h2b7, 3, 3);
    tick(10);
    check_codes(12'h2b7);
    $display("test fast_skew done");
  endtask : test_fast_skew
  task automatic test_stall();
    codeAccept = 1'b0;
    dropCount = 0;
    sample_source_i.send(12'h111, 4, 4);
    sample_source_i.send(12'h222, 4, 4);
    sample_source_i.send(12'h333, 4, 4);
    tick(10);
    check("drops", 12'(dropCount), 12'h001);
    check_codes(12'h2b7);
    codeAccept = 1'b1;
    tick(10);
    check_codes(12'h222);
    $display("test stall done");
  endtask : test_stall
  task automatic test_sleep();
    int n;
    sleepPin = 1'b1;
    tick(5);
    check("asleep", 12'(powerDown_q), 12'h001);
    check("enabled", 12'(outputEnabled_q), 12'h000);
    check("primary", primaryCode_q, 12'h000);
    check("complementary", complementaryCode_q, 12'h000);
    sample_source_i.send(12'h3c7, 4, 4);
    sleepPin = 1'b0;
    tick(400);
    check("asleep", 12'(powerDown_q), 12'h000);
    check("enabled", 12'(outputEnabled_q), 12'h000);
    n = 0;
    while (outputEnabled_q !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check("enabled", 12'(outputEnabled_q), 12'h001);
    check("wake cycles", 12'(n), 12'(dac_pkg::PWRUP_CYCLES + 4 - 400));
    check_codes(12'h3c7);
    $display("test sleep done");
  endtask : test_sleep
  task automatic test_rewake();
    sleepPin = 1'b1;
    tick(5);
    sleepPin = 1'b0;
    tick(50);
    check("asleep", 12'(powerDown_q), 12'h000);
    sleepPin = 1'b1;
    tick(5);
    check("asleep", 12'(powerDown_q), 12'h001);
    sleepPin = 1'b0;
    tick(dac_pkg::PWRUP_CYCLES + 3);
    check("enabled", 12'(outputEnabled_q), 12'h000);
    tick(1);
    check("enabled", 12'(outputEnabled_q), 12'h001);
    check_codes(12'h3c7);
    $display("test rewake done");
  endtask : test_rewake

  // -------------
  // Main sequence
  // -------------
  initial begin
    rst = 1'b1;
    sleepPin = 1'b0;
    codeAccept = 1'b1;
    err_total = 0;
    checks = 0;
    cycles = 0;
    dropCount = 0;
    tick(16);
    check("enabled", 12'(outputEnabled_q), 12'h000);
    rst = 1'b0;
    tick(3);
    check_codes(12'h000);
    test_codes();
    test_fast_skew();
    test_stall();
    test_sleep();
    test_rewake();
    tally_and_finish();
  end
endmodule : tb
